// [sflag_pkg.sv]
// Package: register map, flag positions, reset values and timing constants
package sflag_pkg;
   // Register byte offsets on APB
   localparam logic [7:0] OFF_STATUS  = 8'h00;
   localparam logic [7:0] OFF_DIVISOR = 8'h04;
   localparam logic [7:0] OFF_MODE    = 8'h08;
   localparam logic [7:0] OFF_TRIG    = 8'h0c;
   localparam logic [7:0] OFF_COUNT   = 8'h10;
   // Status flag bit positions
   localparam int BIT_TXLOW = 5;
   localparam int BIT_BRK   = 4;
   localparam int BIT_FER   = 3;
   localparam int BIT_PER   = 2;
   localparam int BIT_RXFUL = 1;
   localparam int BIT_IDLE  = 0;
   // Mode register fields
   localparam int BIT_SYNC  = 7;
   localparam int CKS_LO    = 0;
   // Trigger register fields
   localparam int TTRIG_LO  = 0;
   localparam int RTRIG_LO  = 8;
   // Reset values
   localparam logic [7:0] DIVISOR_RST = 8'hff;
   localparam logic [4:0] TTRIG_RST   = 5'h08;
   localparam logic [4:0] RTRIG_RST   = 5'h01;
   // Bit time multipliers
   localparam int ASYNC_MULT = 64;
   localparam int SYNC_MULT  = 8;
   // Idle timeout in bit times
   localparam int IDLE_ETU   = 15;
   localparam int FIFO_DEPTH = 16;
endpackage

// [sflag_fifo.sv]
// Byte FIFO with per-entry error bits and registered read data
`timescale 1ns/100ps
module sflag_fifo
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Write side
   input  wire logic                     wr_en,
   input  wire logic [WIDTH-1:0]         wr_data,
   // Read side
   input  wire logic                     rd_en,
   output logic      [WIDTH-1:0]         rd_data,
   output logic      [WIDTH-1:0]         head_data,
   output logic      [$clog2(DEPTH):0]   count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             do_wr;
   logic             do_rd;

   // Writes while full are dropped, reads while empty move nothing
   assign do_wr = wr_en && (cnt_r < (AW+1)'(DEPTH));
   assign do_rd = rd_en && (cnt_r != '0);
   assign count = cnt_r;
   assign head_data = mem[rp_r];

   always_ff @(posedge clk)
   begin
      if (do_wr)
         mem[wp_r] <= wr_data;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (do_wr)
            wp_r <= wp_r + 1'b1;
         if (do_rd)
            rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   // Read of an empty FIFO returns stale data, not a defined value
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_data <= '0;
      else if (rd_en)
         rd_data <= mem[rp_r];
   end
endmodule // sflag_fifo

// [sflag_baud.sv]
// Bit-rate generator: prescaler, divisor count and bit-time tick
`timescale 1ns/100ps
module sflag_baud
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Settings
   input  wire logic [7:0]  divisor,
   input  wire logic [1:0]  src_sel,
   input  wire logic        sync_mode,
   // Ticks
   output logic             bit_tick
);
   logic [6:0] pre_r;
   logic [7:0] div_r;
   logic [5:0] mul_r;
   logic       pre_tick;
   logic       div_tick;
   logic [6:0] pre_top;
   logic [5:0] mul_top;

   // Half-step source: 1/2, 2, 8, 32 clocks, as 2^(2n-1)
   always_comb
   begin
      case (src_sel)
         2'b00:   pre_top = 7'h00;
         2'b01:   pre_top = 7'h01;
         2'b10:   pre_top = 7'h07;
         default: pre_top = 7'h1f;
      endcase
      // Scale 0 is half a clock, so the multiplier is halved there only
      if (src_sel == 2'b00)
         mul_top = sync_mode ? 6'(sflag_pkg::SYNC_MULT / 2 - 1) :
                               6'(sflag_pkg::ASYNC_MULT / 2 - 1);
      else
         mul_top = sync_mode ? 6'(sflag_pkg::SYNC_MULT - 1) :
                               6'(sflag_pkg::ASYNC_MULT - 1);
   end

   assign pre_tick = (pre_r == pre_top);
   assign div_tick = pre_tick && (div_r == divisor);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pre_r <= '0;
         div_r <= '0;
         mul_r <= '0;
      end
      else
      begin
         pre_r <= pre_tick ? 7'h00 : pre_r + 7'h01;
         if (div_tick)
            div_r <= 8'h00;
         else if (pre_tick)
            div_r <= div_r + 8'h01;
         if (div_tick)
            mul_r <= bit_tick ? 6'h00 : mul_r + 6'h01;
      end
   end

   assign bit_tick = div_tick && (mul_r == mul_top);
endmodule // sflag_baud

// [sflag_top.sv]
// Status flags, FIFOs and bit-rate divisor of the FIFO serial port
// ---------------------------------------------------------------
// Notes on behaviour
// - Tx low flag sets on drain, reset
// - Software clear: read one, write zero, fill
// - DMA fill clears flag unless counter zero
// - Tx FIFO 16 bytes, full writes dropped
// - Break: framing error, then framing at space
// - Break clears by reset or read-write
// - After break, zero bytes not stored
// - Framing indicator follows FIFO head byte
// - Parity indicator follows FIFO head byte
// - Rx full flag sets above trigger
// - Rx full clears by software or DMA drain
// - Rx FIFO 16 bytes, empty read undefined
// - Idle flag after 15 bit times idle
// - Synchronous mode never sets idle flag
// - Idle clears on empty after read-write
// - Writing one ignored; zero needs prior read
// - Divisor 8 bits, resets to all ones
// - Bit period (N+1) times scale times 64/8
// - Divisor usable over 0 to 255
// - Source select picks 1, 1/4, 1/16, 1/64
// ---------------------------------------------------------------
`timescale 1ns/100ps
module sflag_top
#(
   parameter int DEPTH = sflag_pkg::FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Transmit shifter side
   input  wire logic        TX_TAKE,
   output logic             TX_AVAIL,
   output logic      [7:0]  TX_DATA,
   // Receive shifter side
   input  wire logic        RX_PUSH,
   input  wire logic [7:0]  RX_BYTE,
   input  wire logic        RX_FRAME_ERR,
   input  wire logic        RX_PARITY_ERR,
   input  wire logic        RX_LINE,
   input  wire logic        RX_START,
   // Transfer controller side
   input  wire logic        XFER_TX_WR,
   input  wire logic [7:0]  XFER_TX_DATA,
   input  wire logic        XFER_RX_RD,
   input  wire logic        XFER_CNT_ZERO,
   output logic      [7:0]  XFER_RX_DATA,
   // Bit clock
   output logic             BIT_TICK
);
   localparam int CW = $clog2(DEPTH) + 1;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic        wr_acc;
   logic        rd_acc;
   logic [7:0]  divisor_r;
   logic [7:0]  mode_r;
   logic [9:0]  trig_r;
   logic [5:0]  flags_r;
   logic [5:0]  seen_r;
   logic [CW-1:0] tx_cnt;
   logic [CW-1:0] rx_cnt;
   logic [9:0]  rx_head;
   logic [9:0]  rx_rdata;
   logic        cpu_tx_wr;
   logic        cpu_rx_rd;
   logic        tx_wr;
   logic        rx_rd;
   logic        sync_mode;
   logic        brk_hold_r;
   logic        last_fer_r;
   logic        rx_store;
   logic [8:0]  idle_r;
   logic        tx_wait_r;
   logic        rx_wait_r;
   logic        dr_wait_r;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign PREADY  = 1'b1;
   assign PSLVERR = 1'b0;
   assign wr_acc  = PSEL && PENABLE && PWRITE;
   assign rd_acc  = PSEL && PENABLE && !PWRITE;
   assign sync_mode = mode_r[sflag_pkg::BIT_SYNC];
   // Data window: write to TX, read from RX
   assign cpu_tx_wr = wr_acc && hit(PADDR, sflag_pkg::OFF_COUNT);
   assign cpu_rx_rd = rd_acc && hit(PADDR, sflag_pkg::OFF_COUNT);
   assign tx_wr = cpu_tx_wr || XFER_TX_WR;
   assign rx_rd = cpu_rx_rd || XFER_RX_RD;

   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
         PRDATA <= '0;
      else if (PSEL && !PENABLE && !PWRITE)
      begin
         if (hit(PADDR, sflag_pkg::OFF_STATUS))
            PRDATA <= {26'h0, flags_r[5:4],
                       (rx_cnt != '0) ? rx_head[9:8] : 2'b00,
                       flags_r[1:0]};
         else if (hit(PADDR, sflag_pkg::OFF_COUNT))
            PRDATA <= {24'h0, rx_head[7:0]};
         else if (hit(PADDR, sflag_pkg::OFF_DIVISOR))
            PRDATA <= {24'h0, divisor_r};
         else if (hit(PADDR, sflag_pkg::OFF_MODE))
            PRDATA <= {24'h0, mode_r};
         else if (hit(PADDR, sflag_pkg::OFF_TRIG))
            PRDATA <= {22'h0, trig_r};
         else if (hit(PADDR, 8'h14))
            PRDATA <= {16'h0, 8'(tx_cnt), 8'(rx_cnt)};
         else
            PRDATA <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Configuration
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         divisor_r <= sflag_pkg::DIVISOR_RST;
         mode_r    <= 8'h00;
         trig_r    <= {sflag_pkg::RTRIG_RST, sflag_pkg::TTRIG_RST};
      end
      else if (wr_acc)
      begin
         if (hit(PADDR, sflag_pkg::OFF_DIVISOR))
            divisor_r <= PWDATA[7:0];
         else if (hit(PADDR, sflag_pkg::OFF_MODE))
            mode_r <= PWDATA[7:0];
         else if (hit(PADDR, sflag_pkg::OFF_TRIG))
            trig_r <= PWDATA[9:0];
      end
   end

   // ---------------------------------------------------------------
   // FIFOs
   // ---------------------------------------------------------------
   sflag_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx
   (
      .clk       (REF_CLK),
      .rst       (RST),
      .wr_en     (tx_wr),
      .wr_data   (XFER_TX_WR ? XFER_TX_DATA : PWDATA[7:0]),
      .rd_en     (TX_TAKE),
      .rd_data   (),
      .head_data (TX_DATA),
      .count     (tx_cnt)
   );
   assign TX_AVAIL = (tx_cnt != '0);

   // Zero bytes arriving during a held break are not stored
   assign rx_store = RX_PUSH && !(brk_hold_r && RX_BYTE == 8'h00);

   sflag_fifo #(.WIDTH(10), .DEPTH(DEPTH)) u_rx
   (
      .clk       (REF_CLK),
      .rst       (RST),
      .wr_en     (rx_store),
      .wr_data   ({RX_FRAME_ERR, RX_PARITY_ERR, RX_BYTE}),
      .rd_en     (rx_rd),
      .rd_data   (rx_rdata),
      .head_data (rx_head),
      .count     (rx_cnt)
   );
   assign XFER_RX_DATA = rx_rdata[7:0];

   // ---------------------------------------------------------------
   // Break tracking
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         last_fer_r <= 1'b0;
         brk_hold_r <= 1'b0;
      end
      else
      begin
         if (RX_PUSH)
            last_fer_r <= RX_FRAME_ERR;
         if (RX_PUSH && RX_FRAME_ERR && last_fer_r && !RX_LINE)
            brk_hold_r <= 1'b1;
         else if (RX_LINE)
            brk_hold_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Idle timer
   // ---------------------------------------------------------------
   sflag_baud u_baud
   (
      .clk       (REF_CLK),
      .rst       (RST),
      .divisor   (divisor_r),
      .src_sel   (mode_r[sflag_pkg::CKS_LO +: 2]),
      .sync_mode (sync_mode),
      .bit_tick  (BIT_TICK)
   );

   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
         idle_r <= '0;
      else if (RX_PUSH || RX_START || sync_mode)
         idle_r <= '0;
      else if (BIT_TICK && idle_r < 9'(sflag_pkg::IDLE_ETU))
         idle_r <= idle_r + 9'h001;
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   // Read seen marks: a zero write clears only after a read of one
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
         seen_r <= '0;
      else if (rd_acc && hit(PADDR, sflag_pkg::OFF_STATUS))
         seen_r <= seen_r | flags_r;
      else if (wr_acc && hit(PADDR, sflag_pkg::OFF_STATUS))
         seen_r <= '0;
   end

   // Write-zero arms a pending clear, except break which clears at once; FIFO level completes it
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         flags_r   <= 6'h20;
         tx_wait_r <= 1'b0;
         rx_wait_r <= 1'b0;
         dr_wait_r <= 1'b0;
      end
      else
      begin
         if (wr_acc && hit(PADDR, sflag_pkg::OFF_STATUS))
         begin
            if (!PWDATA[sflag_pkg::BIT_TXLOW] && seen_r[5])
               tx_wait_r <= 1'b1;
            if (!PWDATA[sflag_pkg::BIT_RXFUL] && seen_r[1])
               rx_wait_r <= 1'b1;
            if (!PWDATA[sflag_pkg::BIT_IDLE] && seen_r[0])
               dr_wait_r <= 1'b1;
            if (!PWDATA[sflag_pkg::BIT_BRK] && seen_r[4])
               flags_r[4] <= 1'b0;
         end
         // Tx low: set wins over clear
         if (TX_TAKE && tx_cnt <= CW'(trig_r[4:0]))
            flags_r[5] <= 1'b1;
         else if (tx_cnt > CW'(trig_r[4:0]) &&
                  (tx_wait_r || (XFER_TX_WR && !XFER_CNT_ZERO)))
         begin
            flags_r[5] <= 1'b0;
            tx_wait_r  <= 1'b0;
         end
         if (RX_PUSH && RX_FRAME_ERR && last_fer_r && !RX_LINE)
            flags_r[4] <= 1'b1;
         if (rx_cnt > CW'(trig_r[9:5]))
            flags_r[1] <= 1'b1;
         else if (rx_wait_r || (XFER_RX_RD && !XFER_CNT_ZERO))
         begin
            flags_r[1] <= 1'b0;
            rx_wait_r  <= 1'b0;
         end
         if (!sync_mode && idle_r == 9'(sflag_pkg::IDLE_ETU - 1) &&
             BIT_TICK && rx_cnt != '0 && rx_cnt < CW'(trig_r[9:5]))
            flags_r[0] <= 1'b1;
         else if ((rx_cnt == '0 || (rx_rd && rx_cnt == CW'(1))) &&
                  (dr_wait_r || XFER_RX_RD))
         begin
            flags_r[0] <= 1'b0;
            dr_wait_r  <= 1'b0;
         end
      end
   end
   // Framing and parity bits come live from the head entry
endmodule // sflag_top

// [sflag_top_sva.sv]
// Checker: port-level properties of the serial flag block
`timescale 1ns/100ps
module sflag_chk
#(
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic        REF_CLK,
   input wire logic        RST,
   // APB
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // Line side
   input wire logic        TX_TAKE,
   input wire logic        TX_AVAIL,
   input wire logic [7:0]  TX_DATA,
   input wire logic        XFER_TX_WR,
   input wire logic        BIT_TICK
);
   // ----------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------
   logic       acc;
   logic [7:0] div_r;
   assign acc = PSEL && PENABLE;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
         div_r <= sflag_pkg::DIVISOR_RST;
      else if (acc && PWRITE && PADDR == sflag_pkg::OFF_DIVISOR)
         div_r <= PWDATA[7:0];
   end
   // ----------------------------------------------------------
   // Properties
   // ----------------------------------------------------------
   property p_no_wait;
      acc |-> PREADY && !PSLVERR;
   endproperty
   a_no_wait: assert property (p_no_wait)
      else $error("APB answer not zero-wait or error");
   property p_div_rd;
      acc && !PWRITE && PADDR == sflag_pkg::OFF_DIVISOR
         |-> PRDATA == {24'h0, div_r};
   endproperty
   a_div_rd: assert property (p_div_rd)
      else $error("divisor read differs from last write");
   property p_stat_w;
      acc && !PWRITE && PADDR == sflag_pkg::OFF_STATUS |-> PRDATA[31:6] == 0;
   endproperty
   a_stat_w: assert property (p_stat_w)
      else $error("status upper bits not zero");
   property p_unmap;
      acc && !PWRITE && PADDR > 8'h14 |-> PRDATA == 0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   property p_tick;
      BIT_TICK |=> !BIT_TICK [*3];
   endproperty
   a_tick: assert property (p_tick)
      else $error("bit ticks too close");
   property p_dma_fill;
      XFER_TX_WR |=> TX_AVAIL;
   endproperty
   a_dma_fill: assert property (p_dma_fill)
      else $error("tx fifo empty after transfer write");
   property p_head;
      TX_AVAIL && !TX_TAKE |=> $stable(TX_DATA);
   endproperty
   a_head: assert property (p_head)
      else $error("tx head changed without take");
   property p_drain;
      $fell(TX_AVAIL) |-> $past(TX_TAKE);
   endproperty
   a_drain: assert property (p_drain)
      else $error("tx fifo emptied without take");
   property p_empty;
      !TX_AVAIL && !XFER_TX_WR && !(acc && PWRITE && PADDR == 8'h10)
         |=> !TX_AVAIL;
   endproperty
   a_empty: assert property (p_empty)
      else $error("tx fifo filled without write");
   c_stat: cover property (acc && PADDR == sflag_pkg::OFF_STATUS);
   c_div: cover property (acc && PWRITE && PADDR == sflag_pkg::OFF_DIVISOR);
   c_tick: cover property (BIT_TICK);
endmodule // sflag_chk

bind sflag_top sflag_chk #(.DEPTH(DEPTH)) chk_u (.REF_CLK, .RST, .PSEL,
   .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
   .TX_TAKE, .TX_AVAIL, .TX_DATA, .XFER_TX_WR, .BIT_TICK);

// [serial_peer.sv]
// Remote serial device: character strobes in, byte takes out
`timescale 1ns/100ps
module serial_peer
(
   // Clock
   input  wire logic       REF_CLK,
   // Transmit side
   input  wire logic [7:0] TX_DATA,
   output logic            TX_TAKE,
   // Receive side
   output logic            RX_PUSH,
   output logic [7:0]      RX_BYTE,
   output logic            RX_FRAME_ERR,
   output logic            RX_PARITY_ERR,
   output logic            RX_LINE,
   output logic            RX_START
);
   // ----------------------------------------------------------
   // Line behaviour
   // ----------------------------------------------------------
   initial
   begin
      {TX_TAKE, RX_PUSH, RX_FRAME_ERR, RX_PARITY_ERR, RX_START} = '0;
      RX_BYTE = 8'h00;
      RX_LINE = 1'b1;
   end
   // Line level holds after the character, so a break stays at space
   task automatic send(input logic [7:0] b, input logic fe, pe, ln);
      @(posedge REF_CLK);
      RX_START <= 1'b1;
      RX_LINE  <= ln;
      @(posedge REF_CLK);
      RX_START <= 1'b0;
      RX_PUSH  <= 1'b1;
      RX_BYTE  <= b;
      RX_FRAME_ERR  <= fe;
      RX_PARITY_ERR <= pe;
      @(posedge REF_CLK);
      RX_PUSH  <= 1'b0;
      RX_BYTE  <= ~b;
      RX_FRAME_ERR  <= 1'b0;
      RX_PARITY_ERR <= 1'b0;
   endtask
   task automatic take(output logic [7:0] d);
      @(posedge REF_CLK);
      TX_TAKE <= 1'b1;
      @(posedge REF_CLK);
      d = TX_DATA;
      TX_TAKE <= 1'b0;
   endtask
endmodule // serial_peer

// [tb_serial_fifo_status_and_baud.sv]
// Testbench: register, FIFO flag and bit-rate checks
`timescale 1ns/100ps
module tb_serial_fifo_status_and_baud;
   // ----------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------
   logic        REF_CLK = 0, RST = 1, PSEL, PENABLE, PWRITE, PREADY;
   logic        PSLVERR, TX_TAKE, TX_AVAIL, RX_PUSH, RX_FRAME_ERR;
   logic        RX_PARITY_ERR, RX_LINE, RX_START, XFER_TX_WR, XFER_RX_RD;
   logic        XFER_CNT_ZERO, BIT_TICK;
   logic [7:0]  PADDR, TX_DATA, RX_BYTE, XFER_TX_DATA, XFER_RX_DATA, b, c;
   logic [31:0] PWDATA, PRDATA, q;
   int          mismatches = 0, comparisons = 0, i, n;
   logic [7:0]  bn [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h02};
   logic [7:0]  bm [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80};
   int          bp [5] = '{64, 128, 512, 2048, 12};
   always #10 REF_CLK = ~REF_CLK;
   sflag_top dut_u (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TX_TAKE, .TX_AVAIL, .TX_DATA,
      .RX_PUSH, .RX_BYTE, .RX_FRAME_ERR, .RX_PARITY_ERR, .RX_LINE,
      .RX_START, .XFER_TX_WR, .XFER_TX_DATA, .XFER_RX_RD, .XFER_CNT_ZERO,
      .XFER_RX_DATA, .BIT_TICK);
   serial_peer peer_u (.REF_CLK, .TX_DATA, .TX_TAKE, .RX_PUSH, .RX_BYTE,
      .RX_FRAME_ERR, .RX_PARITY_ERR, .RX_LINE, .RX_START);
   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic chk(input string s, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      @(posedge REF_CLK);
      while (PREADY !== 1'b1) @(posedge REF_CLK);
      q = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
                      input string s);
      apb(1'b0, a, 32'h0);
      chk(s, e, q & m);
   endtask
   task automatic dma(input logic w, input logic [7:0] d, input logic z);
      @(posedge REF_CLK);
      XFER_TX_WR <= w;
      XFER_RX_RD <= !w;
      XFER_TX_DATA <= d;
      XFER_CNT_ZERO <= z;
      @(posedge REF_CLK);
      {XFER_TX_WR, XFER_RX_RD} <= 2'b00;
      @(posedge REF_CLK);
      if (!w) chk("dma data", {24'h0, d}, {24'h0, XFER_RX_DATA});
   endtask
   task automatic gap(input int e);
      int k;
      repeat (2)
      begin
         @(posedge REF_CLK);
         for (k = 0; k < 5000 && BIT_TICK !== 1'b1; k++) @(posedge REF_CLK);
      end
      k = 1;
      @(posedge REF_CLK);
      for (; k < 5000 && BIT_TICK !== 1'b1; k++) @(posedge REF_CLK);
      chk("bit period", e, k);
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------
   // Tests
   // ----------------------------------------------------------
   initial
   begin
      #1000000;
      mismatches++;
      report_and_stop();
   end
   initial
   begin
      {PSEL, PENABLE, PWRITE, XFER_TX_WR, XFER_RX_RD, XFER_CNT_ZERO} = '0;
      {PADDR, XFER_TX_DATA, PWDATA} = '0;
      repeat (3) @(posedge REF_CLK);
      RST <= 1'b0;
      apb(1, 8'h00, 0);
      for (i = 1; i <= 9; i++) apb(1, 8'h10, i);
      rdc(8'h00, 32'hffffffff, 32'h20, "status");
      apb(1, 8'h00, 0);
      rdc(8'h00, 32'h20, 0, "tx low");
      apb(1, 8'h00, 32'h3f);
      rdc(8'h00, 32'h3f, 0, "status");
      rdc(8'h04, 32'hffffffff, 32'hff, "divisor");
      apb(1, 8'h04, 0);
      rdc(8'h04, 32'hffffffff, 0, "divisor");
      rdc(8'h18, 32'hffffffff, 0, "unmapped");
      for (i = 10; i <= 17; i++) apb(1, 8'h10, i);
      rdc(8'h14, 32'hff00, 32'h1000, "tx count");
      for (i = 1; i <= 8; i++)
      begin
         peer_u.take(b);
         chk("tx data", i, {24'h0, b});
      end
      rdc(8'h00, 32'h20, 0, "tx low");
      peer_u.take(b);
      rdc(8'h00, 32'h20, 32'h20, "tx low");
      dma(1, 8'ha1, 1);
      dma(1, 8'ha2, 1);
      rdc(8'h00, 32'h20, 32'h20, "tx low");
      dma(1, 8'ha3, 0);
      rdc(8'h00, 32'h20, 0, "tx low");
      for (i = 0; i < 10; i++) peer_u.take(b);
      apb(1, 8'h0c, 32'h88);
      for (i = 0; i < 5; i++)
      begin
         peer_u.send(8'(8'h11 * (i + 1)), i == 0, i == 1, 1);
         if (i == 3) rdc(8'h00, 32'h02, 0, "rx full");
      end
      rdc(8'h00, 32'h1f, 32'h0a, "rx flags");
      rdc(8'h10, 32'hff, 32'h11, "rx data");
      rdc(8'h00, 32'h1f, 32'h06, "rx flags");
      apb(1, 8'h00, 0);
      rdc(8'h10, 32'hff, 32'h22, "rx data");
      rdc(8'h00, 32'h1f, 0, "rx flags");
      repeat (700) @(posedge REF_CLK);
      rdc(8'h00, 32'h1f, 32'h01, "rx idle");
      for (i = 3; i < 6; i++) dma(0, 8'(8'h11 * i), 0);
      rdc(8'h00, 32'h1f, 0, "rx idle");
      apb(1, 8'h08, 32'h80);
      peer_u.send(8'h66, 0, 0, 1);
      repeat (700) @(posedge REF_CLK);
      rdc(8'h00, 32'h1f, 0, "rx idle");
      rdc(8'h10, 32'hff, 32'h66, "rx data");
      apb(1, 8'h08, 0);
      peer_u.send(8'h00, 1, 0, 1);
      peer_u.send(8'h00, 1, 0, 0);
      apb(0, 8'h14, 0);
      c = q[7:0];
      repeat (3) peer_u.send(8'h00, 1, 0, 0);
      rdc(8'h14, 32'hff, {24'h0, c}, "rx count");
      peer_u.send(8'h77, 0, 0, 1);
      rdc(8'h14, 32'hff, {24'h0, 8'(c + 1)}, "rx count");
      apb(1, 8'h00, 0);
      rdc(8'h00, 32'h10, 32'h10, "break");
      apb(1, 8'h00, 0);
      rdc(8'h00, 32'h10, 0, "break");
      for (i = 0; i < 5; i++)
      begin
         apb(1, 8'h04, {24'h0, bn[i]});
         apb(1, 8'h08, {24'h0, bm[i]});
         gap(bp[i]);
      end
      report_and_stop();
   end
endmodule // tb_serial_fifo_status_and_baud
